// ### shared/gtm_cfg.svh
// register offsets, field positions and reset values of the general timer module
// assumes a 12-bit byte address on the apb port, one 32-bit word per register
`ifndef GTM_CFG_SVH
`define GTM_CFG_SVH

// byte offsets
`define GTM_OFS_CFG 12'h000
`define GTM_OFS_AMODE 12'h004
`define GTM_OFS_BMODE 12'h008
`define GTM_OFS_CTL 12'h00C
`define GTM_OFS_IMR 12'h018
`define GTM_OFS_RIS 12'h01C
`define GTM_OFS_MIS 12'h020
`define GTM_OFS_ICR 12'h024
`define GTM_OFS_ALOAD 12'h028
`define GTM_OFS_BLOAD 12'h02C
`define GTM_OFS_AMATCH 12'h030
`define GTM_OFS_BMATCH 12'h034
`define GTM_OFS_APRE 12'h038
`define GTM_OFS_BPRE 12'h03C
`define GTM_OFS_ACNT 12'h048
`define GTM_OFS_BCNT 12'h04C

// control register fields
`define GTM_CTL_A_RUN 0
`define GTM_CTL_A_STALL 1
`define GTM_CTL_CAL_OVR 4
`define GTM_CTL_A_TRIG 5
`define GTM_CTL_B_RUN 8
`define GTM_CTL_B_STALL 9
`define GTM_CTL_B_TRIG 13
`define GTM_CTL_MASK 32'h0000_2333

// status, mask and clear fields
`define GTM_IRQ_A_TMO 0
`define GTM_IRQ_CAL 3
`define GTM_IRQ_B_TMO 8
`define GTM_IRQ_MASK 32'h0000_0109

// reset values and the calendar start value
`define GTM_RST_CNT 16'hFFFF
`define GTM_RST_LOAD 16'hFFFF
`define GTM_RST_MATCH 16'hFFFF
`define GTM_RST_PRE 8'h00
`define GTM_RST_CTL 32'h0000_0000
`define GTM_CAL_START 32'h0000_0001

// calendar input divider: 32.768 khz edges per 1 hz step
`define GTM_CAL_IN_HZ 32768
`define GTM_CAL_OUT_HZ 1

`endif

// ### shared/gtm_pkg.sv
// types shared by the general timer module and its bench
// assumes gtm_cfg.svh supplies the numeric constants
package gtm_pkg;

	// module configuration codes
	typedef enum logic [2:0] {
		GTM_CFG_OS32 = 3'b000,
		GTM_CFG_CAL = 3'b001,
		GTM_CFG_SPLIT = 3'b100
	} gtm_cfg_e;

	// half mode field codes
	typedef enum logic [1:0] {
		GTM_MODE_NONE = 2'b00,
		GTM_MODE_ONESHOT = 2'b01,
		GTM_MODE_PERIODIC = 2'b10,
		GTM_MODE_CAPTURE = 2'b11
	} gtm_mode_e;

	// apb request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} gtm_apb_req_s;

endpackage : gtm_pkg

// ### rtl/gtm_timer.sv
// general timer module: two 16-bit halves, 32-bit one-shot/periodic and calendar modes
// assumes an apb master on sys_clk and a capture pin already synchronous-safe via the local synchroniser
//
// Functional notes
// R1: after reset the module is idle with all control registers at defaults
// R2: both half counters and both half load registers reset to 16'hFFFF
// R3: both half prescale registers reset to zero
// R4: config 0 selects 32-bit one-shot/periodic, 1 selects 32-bit calendar
// R5: config 4 selects split 16-bit operation with independent halves
// R6: 32-bit modes act only as one timer; split mode lets halves differ
// R7: in 32-bit modes a half-A load write fills B from upper, A from lower
// R8: in 32-bit modes half-A count read returns B upper, A lower
// R9: 32-bit one-shot/periodic uses the half-A mode field; half-B mode ignored
// R10: running counter counts down, reloads the 32-bit load value after zero
// R11: one-shot stops at zero and clears half-A run; periodic keeps going; the code reloads the load value on the zero cycle and then holds it
// R12: zero sets the half-A timeout raw flag until software clears it
// R13: unmasked timeout also shows in the half-A timeout masked flag
// R14: timeout pulses the converter trigger only when its enable is set
// R15: load rewrite while running takes effect next clock, counting continues
// R16: half-A debug stall freezes counting while the processor is halted
// R17: calendar mode counts up; first selection loads the value one
// R18: software writes later calendar compare values to the half-A match register
// R19: a 32.768 khz pin clock is divided to 1 hz for the calendar counter
// R20: calendar count equal to match rolls over to zero and keeps counting
// R21: calendar match sets raw flag; unmasked it sets masked flag and interrupt
// R22: calendar clear bit clears calendar raw and masked flags
// R23: calendar stall override keeps the calendar running during debug halt
// R24: writing one to a clear bit clears that flag; zero does nothing
// R25: interrupt is high while any masked flag is set
`timescale 1ns/1ps
`include "gtm_cfg.svh"

module gtm_timer #(
	parameter int CAL_DIV = `GTM_CAL_IN_HZ / `GTM_CAL_OUT_HZ
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// apb slave
	input gtm_pkg::gtm_apb_req_s apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// debug halt from the processor
	input wire logic dbg_halt,
	// even capture/compare pin, input side only
	input wire logic capture_compare_pin,
	// events
	output logic irq,
	output logic adc_trig
);
	import gtm_pkg::*;

	localparam int DIV_W = $clog2(CAL_DIV);

	////////////////////////////////////////////////////////////////////////////////
	// decoding

	function automatic logic gtm_mapped(input logic [11:0] a);
		case (a)
			`GTM_OFS_CFG, `GTM_OFS_AMODE, `GTM_OFS_BMODE, `GTM_OFS_CTL, `GTM_OFS_IMR,
			`GTM_OFS_RIS, `GTM_OFS_MIS, `GTM_OFS_ICR, `GTM_OFS_ALOAD, `GTM_OFS_BLOAD,
			`GTM_OFS_AMATCH, `GTM_OFS_BMATCH, `GTM_OFS_APRE, `GTM_OFS_BPRE,
			`GTM_OFS_ACNT, `GTM_OFS_BCNT: gtm_mapped = 1'b1;
			default: gtm_mapped = 1'b0;
		endcase
	endfunction : gtm_mapped

	function automatic logic gtm_wr_to(input gtm_apb_req_s r, input logic [11:0] a);
		gtm_wr_to = r.psel && r.penable && r.pwrite && (r.paddr == a);
	endfunction : gtm_wr_to

	////////////////////////////////////////////////////////////////////////////////
	// state

	logic [2:0] cfg_q;
	logic [1:0] mode_q [2];
	logic [31:0] ctl_q;
	logic [31:0] imr_q;
	logic [31:0] ris_q;
	logic [15:0] cnt_q [2];
	logic [15:0] load_q [2];
	logic [15:0] match_q [2];
	logic [7:0] pre_q [2];
	logic cal_seen_q;
	logic [DIV_W-1:0] div_q;
	logic cap_s1_q;
	logic cap_s2_q;
	logic cap_s3_q;
	logic adc_trig_q;
	logic [31:0] prdata_q;
	logic pslverr_q;

	logic setup;
	logic cfg_wr;
	logic ctl_wr;
	logic [1:0] load_wr;
	logic is_os32;
	logic is_cal;
	logic is_split;
	logic [31:0] cnt32;
	logic [31:0] load32;
	logic [31:0] match32;
	logic [1:0] halted;
	logic [1:0] run;
	logic adv32;
	logic cal_step;
	logic cal_hit;
	logic sec_tick;
	logic [1:0] tmo;
	logic [31:0] set_v;
	logic [31:0] clr_v;
	logic [31:0] rd_mux;

	assign setup = apb_req.psel && !apb_req.penable;
	assign cfg_wr = gtm_wr_to(apb_req, `GTM_OFS_CFG);
	assign ctl_wr = gtm_wr_to(apb_req, `GTM_OFS_CTL);
	assign load_wr[0] = gtm_wr_to(apb_req, `GTM_OFS_ALOAD);
	assign load_wr[1] = gtm_wr_to(apb_req, `GTM_OFS_BLOAD);

	// other config codes leave the module idle
	assign is_os32 = (cfg_q == GTM_CFG_OS32); // [R4]
	assign is_cal = (cfg_q == GTM_CFG_CAL); // [R4]
	assign is_split = (cfg_q == GTM_CFG_SPLIT); // [R5]

	assign cnt32 = {cnt_q[1], cnt_q[0]};
	assign load32 = {load_q[1], load_q[0]};
	assign match32 = {match_q[1], match_q[0]};
	assign run[0] = ctl_q[`GTM_CTL_A_RUN];
	assign run[1] = ctl_q[`GTM_CTL_B_RUN];
	assign halted[0] = ctl_q[`GTM_CTL_A_STALL] && dbg_halt; // [R16]
	assign halted[1] = ctl_q[`GTM_CTL_B_STALL] && dbg_halt;

	// only half A steers the 32-bit one-shot/periodic timer; the calendar also stops on the half-B stall
	assign adv32 = is_os32 && run[0] && !halted[0]; // [R6] [R9] [R16]
	assign sec_tick = cap_s2_q && !cap_s3_q && (div_q == DIV_W'(CAL_DIV - 1)); // [R19]
	assign cal_step = is_cal && run[0] && sec_tick
		&& (ctl_q[`GTM_CTL_CAL_OVR] || !(halted[0] || halted[1])); // [R23]
	assign cal_hit = cal_step && (cnt32 == match32); // [R20]

	assign tmo[0] = (adv32 && cnt32 == 32'h0000_0000)
		|| (is_split && run[0] && !halted[0] && cnt_q[0] == 16'h0000); // [R12]
	assign tmo[1] = is_split && run[1] && !halted[1] && cnt_q[1] == 16'h0000; // [R6]

	always_comb
	begin
		set_v = 32'h0000_0000;
		set_v[`GTM_IRQ_A_TMO] = tmo[0];
		set_v[`GTM_IRQ_B_TMO] = tmo[1];
		set_v[`GTM_IRQ_CAL] = cal_hit; // [R21]
	end

	// [R24] [R22]
	assign clr_v = gtm_wr_to(apb_req, `GTM_OFS_ICR) ? (apb_req.pwdata & `GTM_IRQ_MASK) : 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////////
	// configuration registers

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cfg_q <= GTM_CFG_OS32; // [R1]
			imr_q <= 32'h0000_0000;
			for (int h = 0; h < 2; h++)
			begin
				mode_q[h] <= GTM_MODE_NONE;
				load_q[h] <= `GTM_RST_LOAD; // [R2]
				match_q[h] <= `GTM_RST_MATCH;
				pre_q[h] <= `GTM_RST_PRE; // [R3]
			end
		end
		else
		begin
			if (cfg_wr)
				cfg_q <= apb_req.pwdata[2:0];
			if (gtm_wr_to(apb_req, `GTM_OFS_IMR))
				imr_q <= apb_req.pwdata & `GTM_IRQ_MASK;
			if (gtm_wr_to(apb_req, `GTM_OFS_AMODE))
				mode_q[0] <= apb_req.pwdata[1:0];
			if (gtm_wr_to(apb_req, `GTM_OFS_BMODE))
				mode_q[1] <= apb_req.pwdata[1:0];
			if (gtm_wr_to(apb_req, `GTM_OFS_APRE))
				pre_q[0] <= apb_req.pwdata[7:0];
			if (gtm_wr_to(apb_req, `GTM_OFS_BPRE))
				pre_q[1] <= apb_req.pwdata[7:0];
			// a half-A write fills both halves in the 32-bit modes
			if (load_wr[0])
			begin
				load_q[0] <= apb_req.pwdata[15:0];
				if (!is_split)
					load_q[1] <= apb_req.pwdata[31:16]; // [R7]
			end
			else if (load_wr[1])
				load_q[1] <= apb_req.pwdata[15:0];
			if (gtm_wr_to(apb_req, `GTM_OFS_AMATCH))
			begin
				match_q[0] <= apb_req.pwdata[15:0];
				if (!is_split)
					match_q[1] <= apb_req.pwdata[31:16]; // [R18]
			end
			else if (gtm_wr_to(apb_req, `GTM_OFS_BMATCH))
				match_q[1] <= apb_req.pwdata[15:0];
		end
	end

	// software write wins over the hardware one-shot clear in the same cycle
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			ctl_q <= `GTM_RST_CTL; // [R1]
		else if (ctl_wr)
			ctl_q <= apb_req.pwdata & `GTM_CTL_MASK;
		else
		begin
			if (tmo[0] && mode_q[0] == GTM_MODE_ONESHOT)
				ctl_q[`GTM_CTL_A_RUN] <= 1'b0; // [R11]
			if (tmo[1] && mode_q[1] == GTM_MODE_ONESHOT)
				ctl_q[`GTM_CTL_B_RUN] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// counters

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt_q[0] <= `GTM_RST_CNT; // [R2]
			cnt_q[1] <= `GTM_RST_CNT;
			cal_seen_q <= 1'b0;
		end
		else if (cfg_wr && apb_req.pwdata[2:0] == GTM_CFG_CAL && !cal_seen_q)
		begin
			{cnt_q[1], cnt_q[0]} <= `GTM_CAL_START; // [R17]
			cal_seen_q <= 1'b1;
		end
		else if (is_os32 && load_wr[0])
			{cnt_q[1], cnt_q[0]} <= apb_req.pwdata; // [R15]
		else if (adv32)
			{cnt_q[1], cnt_q[0]} <= (cnt32 == 32'h0000_0000) ? load32 : cnt32 - 32'h0000_0001; // [R10]
		else if (cal_step)
			{cnt_q[1], cnt_q[0]} <= cal_hit ? 32'h0000_0000 : cnt32 + 32'h0000_0001; // [R17] [R20]
		else if (is_split)
		begin
			for (int h = 0; h < 2; h++)
			begin
				if (load_wr[h])
					cnt_q[h] <= apb_req.pwdata[15:0];
				else if (run[h] && !halted[h])
					cnt_q[h] <= (cnt_q[h] == 16'h0000) ? load_q[h] : cnt_q[h] - 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// calendar input: synchroniser and 1 hz divider

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cap_s1_q <= 1'b0;
			cap_s2_q <= 1'b0;
			cap_s3_q <= 1'b0;
		end
		else
		begin
			cap_s1_q <= capture_compare_pin;
			cap_s2_q <= cap_s1_q;
			cap_s3_q <= cap_s2_q;
		end
	end

	// divider keeps running under debug halt so the second boundary stays true
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			div_q <= '0;
		else if (!(is_cal && run[0]))
			div_q <= '0;
		else if (cap_s2_q && !cap_s3_q)
			div_q <= sec_tick ? '0 : div_q + DIV_W'(1); // [R19]
	end

	////////////////////////////////////////////////////////////////////////////////
	// flags and events

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			ris_q <= 32'h0000_0000;
		else
			ris_q <= (ris_q & ~clr_v) | set_v; // [R12] [R21] [R24]
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			adc_trig_q <= 1'b0;
		else
			adc_trig_q <= (tmo[0] && ctl_q[`GTM_CTL_A_TRIG])
				|| (tmo[1] && ctl_q[`GTM_CTL_B_TRIG]); // [R14]
	end

	assign adc_trig = adc_trig_q;
	assign irq = |(ris_q & imr_q); // [R13] [R21] [R25]

	////////////////////////////////////////////////////////////////////////////////
	// apb read side: data sampled in setup, presented in a zero-wait access

	always_comb
	begin
		case (apb_req.paddr)
			`GTM_OFS_CFG: rd_mux = {29'h0, cfg_q};
			`GTM_OFS_AMODE: rd_mux = {30'h0, mode_q[0]};
			`GTM_OFS_BMODE: rd_mux = {30'h0, mode_q[1]};
			`GTM_OFS_CTL: rd_mux = ctl_q;
			`GTM_OFS_IMR: rd_mux = imr_q;
			`GTM_OFS_RIS: rd_mux = ris_q;
			`GTM_OFS_MIS: rd_mux = ris_q & imr_q; // [R13]
			`GTM_OFS_ALOAD: rd_mux = is_split ? {16'h0, load_q[0]} : load32;
			`GTM_OFS_BLOAD: rd_mux = {16'h0, load_q[1]};
			`GTM_OFS_AMATCH: rd_mux = is_split ? {16'h0, match_q[0]} : match32;
			`GTM_OFS_BMATCH: rd_mux = {16'h0, match_q[1]};
			`GTM_OFS_APRE: rd_mux = {24'h0, pre_q[0]};
			`GTM_OFS_BPRE: rd_mux = {24'h0, pre_q[1]};
			`GTM_OFS_ACNT: rd_mux = is_split ? {16'h0, cnt_q[0]} : cnt32; // [R8]
			`GTM_OFS_BCNT: rd_mux = {16'h0, cnt_q[1]};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end
		else if (setup)
		begin
			prdata_q <= apb_req.pwrite ? 32'h0000_0000 : rd_mux;
			pslverr_q <= !gtm_mapped(apb_req.paddr);
		end
	end

	assign prdata = prdata_q;
	assign pslverr = pslverr_q;
	assign pready = 1'b1;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	chk_ctl_reset: assert property (@(posedge sys_clk) !rstn |-> ctl_q == 32'h0 && cfg_q == 3'h0) // [R1]
		else $error("control state not cleared in reset");
	chk_half_reset: assert property (@(posedge sys_clk) !rstn |-> cnt32 == 32'hFFFF_FFFF && load32 == 32'hFFFF_FFFF) // [R2]
		else $error("counters or loads not all ones in reset");
	chk_pre_reset: assert property (@(posedge sys_clk) !rstn |-> pre_q[0] == 8'h00 && pre_q[1] == 8'h00) // [R3]
		else $error("prescalers not zero in reset");
	chk_os_reload: assert property (@(posedge sys_clk) disable iff (!rstn) // [R10]
		adv32 && cnt32 == 32'h0 && !load_wr[0] && !cfg_wr |=> cnt32 == $past(load32))
		else $error("32-bit counter did not reload after zero");
	chk_os_stop: assert property (@(posedge sys_clk) disable iff (!rstn) // [R11]
		tmo[0] && mode_q[0] == GTM_MODE_ONESHOT && !ctl_wr |=> !run[0] ##1 $stable(cnt32) || $past(load_wr[0]))
		else $error("one-shot did not stop at zero");
	chk_tmo_flag: assert property (@(posedge sys_clk) disable iff (!rstn) // [R12]
		tmo[0] || (ris_q[`GTM_IRQ_A_TMO] && !clr_v[`GTM_IRQ_A_TMO]) |=> ris_q[`GTM_IRQ_A_TMO])
		else $error("timeout flag not held");
	chk_tmo_irq: assert property (@(posedge sys_clk) disable iff (!rstn) // [R13]
		tmo[0] && imr_q[`GTM_IRQ_A_TMO] |=> irq)
		else $error("unmasked timeout raised no interrupt");
	chk_adc_trig: assert property (@(posedge sys_clk) disable iff (!rstn) // [R14]
		adc_trig |-> $past(tmo[0] && ctl_q[`GTM_CTL_A_TRIG]) || $past(tmo[1] && ctl_q[`GTM_CTL_B_TRIG]))
		else $error("converter trigger without enabled timeout");
	chk_stall_hold: assert property (@(posedge sys_clk) disable iff (!rstn) // [R16]
		is_os32 && halted[0] && !load_wr[0] && !cfg_wr |=> $stable(cnt32))
		else $error("32-bit counter moved during debug halt");
	chk_cal_roll: assert property (@(posedge sys_clk) disable iff (!rstn) // [R20]
		cal_hit && !cfg_wr |=> cnt32 == 32'h0 && ris_q[`GTM_IRQ_CAL])
		else $error("calendar did not roll over on match");
	chk_cal_clear: assert property (@(posedge sys_clk) disable iff (!rstn) // [R22]
		clr_v[`GTM_IRQ_CAL] && !cal_hit |=> !ris_q[`GTM_IRQ_CAL])
		else $error("calendar flag not cleared");

endmodule : gtm_timer

// ### verif/gtm_pin_model.sv
// far side of the timer: calendar clock source on the even pin and converter trigger sink
// assumes the bench opens pin_run only while the calendar should advance
`timescale 1ns/1ps

module gtm_pin_model #(
	parameter realtime HALF_NS = 15259.0
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// bench control
	input wire logic pin_run,
	// pins
	output logic capture_compare_pin,
	input wire logic adc_trig,
	output int trig_count
);

	////////////////////////////////////////////////////////////////////////
	// 32.768 khz source, stands low outside calendar runs
	// half period is not a multiple of the system period, so phases drift
	initial
	begin
		capture_compare_pin = 1'b0;
		forever
		begin
			#(HALF_NS);
			capture_compare_pin = pin_run ? ~capture_compare_pin : 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// converter side counts trigger pulses
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			trig_count <= 0;
		else if (adc_trig)
			trig_count <= trig_count + 1;
	end

endmodule : gtm_pin_model

// ### verif/dual_half_timer_32bit_modes_test.sv
// self-checking bench of the general timer: reset state, 32-bit modes, split mode, calendar
// assumes gtm_timer with zero-wait apb and the pin model on the far side
`timescale 1ns/1ps
`include "gtm_cfg.svh"

module dual_half_timer_32bit_modes_test;
	import gtm_pkg::*;

	logic sys_clk, rstn, dbg_halt, pin_run, pready, pslverr, irq, adc_trig, capture_compare_pin, err;
	gtm_apb_req_s req;
	logic [31:0] prdata, rd, v, nl;
	int trig_count, n_mismatch, tests_run, seed;

	gtm_timer #(.CAL_DIV(4)) dut (.sys_clk(sys_clk), .rstn(rstn), .apb_req(req), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .dbg_halt(dbg_halt),
		.capture_compare_pin(capture_compare_pin), .irq(irq), .adc_trig(adc_trig));
	gtm_pin_model pins (.sys_clk(sys_clk), .rstn(rstn), .pin_run(pin_run),
		.capture_compare_pin(capture_compare_pin), .adc_trig(adc_trig), .trig_count(trig_count));

	////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [31:0] join_halves(input logic [15:0] hi, input logic [15:0] lo);
		return {hi, lo};
	endfunction : join_halves

	function automatic logic [31:0] ctl_word(input logic run, input logic stall, input logic ovr, input logic trig);
		return (32'(run) << `GTM_CTL_A_RUN) | (32'(stall) << `GTM_CTL_A_STALL) |
			(32'(ovr) << `GTM_CTL_CAL_OVR) | (32'(trig) << `GTM_CTL_A_TRIG);
	endfunction : ctl_word

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// waits as long as the slave asks; only the watchdog ends a stuck transfer
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge sys_clk);
		req.penable <= 1'b1;
		do
			@(posedge sys_clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] exp,
		input logic [31:0] m = 32'hFFFF_FFFF);
		apb(1'b0, a, 32'h0000_0000);
		chk(name, rd & m, exp & m);
	endtask : rdc

	// bounded poll; a miss shows in the comparison that follows
	task automatic poll_ris(input logic [31:0] m, input int lim);
		int n;
		n = 0;
		do
		begin
			apb(1'b0, `GTM_OFS_RIS, 32'h0000_0000);
			n++;
		end
		while ((rd & m) !== m && n < lim);
	endtask : poll_ris

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report

	////////////////////////////////////////////////////////////////////////
	// clock and watchdog
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	initial
	begin
		#(900_000);
		n_mismatch++;
		final_report();
	end

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		seed = 32'h7BF9;
		req = '0;
		dbg_halt = 1'b0;
		pin_run = 1'b0;
		rstn = 1'b1;
		n_mismatch = 0;
		tests_run = 0;
		// a clean falling edge, so the asynchronous reset acts before the first clock edge
		#1;
		rstn = 1'b0;
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		rdc("cfg", `GTM_OFS_CFG, 32'h0000_0000);
		rdc("ctl", `GTM_OFS_CTL, `GTM_RST_CTL);
		rdc("imr", `GTM_OFS_IMR, 32'h0000_0000);
		rdc("ris", `GTM_OFS_RIS, 32'h0000_0000);
		rdc("acnt", `GTM_OFS_ACNT, join_halves(`GTM_RST_CNT, `GTM_RST_CNT));
		rdc("bload", `GTM_OFS_BLOAD, 32'(`GTM_RST_LOAD), 32'h0000_FFFF);
		rdc("apre", `GTM_OFS_APRE, 32'(`GTM_RST_PRE));
		rdc("bpre", `GTM_OFS_BPRE, 32'(`GTM_RST_PRE));
		apb(1'b0, 12'h0FC, 32'h0000_0000);
		chk("unmapped err", 32'(err), 32'h0000_0001);
		// one-shot, unmasked, trigger enabled; half-B mode set to periodic must not matter
		wr(`GTM_OFS_CFG, 32'(GTM_CFG_OS32));
		rdc("cfg os32", `GTM_OFS_CFG, 32'(GTM_CFG_OS32));
		wr(`GTM_OFS_AMODE, 32'(GTM_MODE_ONESHOT));
		wr(`GTM_OFS_BMODE, 32'(GTM_MODE_PERIODIC));
		v = $random(seed);
		wr(`GTM_OFS_ALOAD, v);
		rdc("bload upper", `GTM_OFS_BLOAD, v >> 16, 32'h0000_FFFF);
		nl = 32'h0000_0004 + (32'($random(seed)) & 32'h0000_000F);
		wr(`GTM_OFS_ALOAD, nl);
		wr(`GTM_OFS_IMR, 32'h1 << `GTM_IRQ_A_TMO);
		wr(`GTM_OFS_CTL, ctl_word(1'b1, 1'b0, 1'b0, 1'b1));
		poll_ris(32'h1, 100);
		chk("ris tmo", rd, 32'h1 << `GTM_IRQ_A_TMO);
		rdc("mis tmo", `GTM_OFS_MIS, 32'h1 << `GTM_IRQ_A_TMO);
		chk("irq", 32'(irq), 32'h0000_0001);
		chk("trig", 32'(trig_count), 32'h0000_0001);
		rdc("ctl run cleared", `GTM_OFS_CTL, ctl_word(1'b0, 1'b0, 1'b0, 1'b1));
		rdc("acnt reload", `GTM_OFS_ACNT, nl);
		wr(`GTM_OFS_ICR, 32'h0000_0000);
		rdc("ris icr0", `GTM_OFS_RIS, 32'h1 << `GTM_IRQ_A_TMO);
		wr(`GTM_OFS_ICR, 32'h1 << `GTM_IRQ_A_TMO);
		rdc("ris icr1", `GTM_OFS_RIS, 32'h0000_0000);
		chk("irq clr", 32'(irq), 32'h0000_0000);
		// periodic, masked, no trigger
		wr(`GTM_OFS_IMR, 32'h0000_0000);
		wr(`GTM_OFS_AMODE, 32'(GTM_MODE_PERIODIC));
		wr(`GTM_OFS_CTL, ctl_word(1'b1, 1'b0, 1'b0, 1'b0));
		poll_ris(32'h1, 100);
		chk("ris per", rd, 32'h1 << `GTM_IRQ_A_TMO);
		chk("irq masked", 32'(irq), 32'h0000_0000);
		chk("no trig", 32'(trig_count), 32'h0000_0001);
		wr(`GTM_OFS_ICR, 32'h1 << `GTM_IRQ_A_TMO);
		poll_ris(32'h1, 100);
		chk("ris again", rd, 32'h1 << `GTM_IRQ_A_TMO);
		rdc("ctl still run", `GTM_OFS_CTL, ctl_word(1'b1, 1'b0, 1'b0, 1'b0));
		wr(`GTM_OFS_ALOAD, 32'h0001_0000);
		apb(1'b0, `GTM_OFS_ACNT, 32'h0000_0000);
		chk("load while run", 32'(rd > 32'h0000_FF00 && rd <= 32'h0001_0000), 32'h1);
		dbg_halt <= 1'b1;
		wr(`GTM_OFS_CTL, ctl_word(1'b1, 1'b1, 1'b0, 1'b0));
		apb(1'b0, `GTM_OFS_ACNT, 32'h0000_0000);
		v = rd;
		rdc("frozen", `GTM_OFS_ACNT, v);
		dbg_halt <= 1'b0;
		apb(1'b0, `GTM_OFS_ACNT, 32'h0000_0000);
		chk("resumed", 32'(rd !== v), 32'h1);
		// split mode: half-A load write leaves half B alone
		wr(`GTM_OFS_CTL, 32'h0000_0000);
		wr(`GTM_OFS_CFG, 32'(GTM_CFG_SPLIT));
		rdc("cfg split", `GTM_OFS_CFG, 32'(GTM_CFG_SPLIT));
		v = $random(seed);
		wr(`GTM_OFS_ALOAD, v);
		rdc("aload split", `GTM_OFS_ALOAD, v, 32'h0000_FFFF);
		rdc("bload split", `GTM_OFS_BLOAD, 32'h0000_0001, 32'h0000_FFFF);
		// calendar with debug halt held and override set
		wr(`GTM_OFS_ICR, `GTM_IRQ_MASK);
		wr(`GTM_OFS_CFG, 32'(GTM_CFG_CAL));
		rdc("cal start", `GTM_OFS_ACNT, `GTM_CAL_START);
		wr(`GTM_OFS_AMATCH, 32'h0000_0003);
		wr(`GTM_OFS_IMR, 32'h1 << `GTM_IRQ_CAL);
		dbg_halt <= 1'b1;
		pin_run <= 1'b1;
		wr(`GTM_OFS_CTL, ctl_word(1'b1, 1'b1, 1'b1, 1'b0));
		poll_ris(32'h1 << `GTM_IRQ_CAL, 20000);
		chk("ris cal", rd, 32'h1 << `GTM_IRQ_CAL);
		rdc("rollover", `GTM_OFS_ACNT, 32'h0000_0000);
		rdc("mis cal", `GTM_OFS_MIS, 32'h1 << `GTM_IRQ_CAL);
		chk("irq cal", 32'(irq), 32'h0000_0001);
		wr(`GTM_OFS_ICR, 32'h1 << `GTM_IRQ_CAL);
		rdc("ris cal clr", `GTM_OFS_RIS, 32'h0000_0000);
		rdc("mis cal clr", `GTM_OFS_MIS, 32'h0000_0000);
		chk("irq cal clr", 32'(irq), 32'h0000_0000);
		pin_run <= 1'b0;
		dbg_halt <= 1'b0;
		final_report();
	end

endmodule : dual_half_timer_32bit_modes_test
